// >>> design/octal_switch_spi_diag_control.v
// Purpose: serial control and diagnosis of an eight channel switch
// Assumes: serial pins and analog flags are asynchronous to CLK;
//   the serial clock is at most a quarter of the core clock rate
// Notes: pins are oversampled, so every serial edge is seen a few
//   core cycles late; the frame is judged on the select rise;
//   a select rise lets the fault pin go high for one cycle, even
//   while a lasting error keeps its latch set
`timescale 1ns/1ns
`include "octal_switch_regs.vh"

module octal_switch_spi_diag_control #(
  parameter NUM_CH = `NUM_CH,
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] FILT_CYCLES = `FILT_CYCLES
) (
  // clock and reset
  input wire CLK,
  input wire RST_B,
  // serial link
  input wire SCLK,
  input wire CS_B,
  input wire SI,
  output reg SO_OUT,
  output wire SO_OE,
  // open-drain fault indicator
  output wire FAULT_B_OUT,
  output wire FAULT_B_OE,
  // direct channel pads for channels 1 to 4
  input wire [3:0] DIRECT_CHANNEL_PAD,
  input wire [3:0] DIRECT_CHANNEL_PAD_CONN,
  // input polarity select pin
  input wire INPUT_POLARITY_SELECT,
  input wire INPUT_POLARITY_SELECT_CONN,
  // per-channel analog flags
  input wire [NUM_CH-1:0] CURRENT_LIMIT_FLAG,
  input wire [NUM_CH-1:0] OVERTEMP_FLAG,
  input wire [NUM_CH-1:0] BELOW_UNLOADED_THRESHOLD,
  input wire [NUM_CH-1:0] BELOW_GND_SHORT_THRESHOLD,
  // channel gate drives
  output reg [NUM_CH-1:0] GATE_ON
);

  localparam ND = `NUM_DIRECT;
  localparam FB = `FRAME_BITS;
  // synchroniser width: sclk, cs, si, pads, pad conn, pol, pol conn,
  // then four flag vectors
  localparam SW = 3 + 2 * ND + 2 + 4 * NUM_CH;
  // synchroniser reset image: the select bit starts high, its idle
  // level, so leaving reset neither drives the serial output nor
  // looks like a select fall that would open a frame
  localparam [SW-1:0] SYNC_RST = {{(SW-2){1'b0}}, 2'b10};

  // frame states
  localparam ST_IDLE = 1'b0;
  localparam ST_FRAME = 1'b1;

  wire [SW-1:0] pin_raw;
  reg [SW-1:0] sync1_r;
  reg [SW-1:0] sync2_r;
  reg sclk_d_r;
  reg cs_d_r;

  wire sclk_s;
  wire cs_s;
  wire si_s;
  wire [ND-1:0] pad_s;
  wire [ND-1:0] pad_conn_s;
  wire pol_s;
  wire pol_conn_s;
  wire [NUM_CH-1:0] ilim_s;
  wire [NUM_CH-1:0] ot_s;
  wire [NUM_CH-1:0] below_ol_s;
  wire [NUM_CH-1:0] below_gnd_s;

  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire cs_rise;

  reg state_r;
  reg state_nxt;
  reg [FB-1:0] sh_out_r;
  reg [FB-1:0] sh_out_nxt;
  reg [FB-1:0] sh_in_r;
  reg [FB-1:0] sh_in_nxt;
  reg [4:0] bit_cnt_r;
  reg [4:0] bit_cnt_nxt;
  reg so_nxt;
  reg [NUM_CH-1:0] data_r;
  reg [NUM_CH-1:0] data_nxt;

  wire [7:0] rx_ctrl;
  wire [7:0] rx_data;
  wire frame_full;

  wire pol_high;
  wire [ND-1:0] pad_active;
  wire [NUM_CH-1:0] direct_ok;
  wire [NUM_CH-1:0] gate_nxt;

  wire [2*NUM_CH-1:0] live_code;
  reg [2*NUM_CH-1:0] err_code_r;
  reg [NUM_CH-1:0] err_vld_r;
  wire [2*NUM_CH-1:0] report_code;
  wire [FB-1:0] status_word;
  reg fault_rel_r;

  // gather every asynchronous pin into one synchroniser vector
  assign pin_raw = {BELOW_GND_SHORT_THRESHOLD, BELOW_UNLOADED_THRESHOLD,
                    OVERTEMP_FLAG, CURRENT_LIMIT_FLAG,
                    INPUT_POLARITY_SELECT_CONN, INPUT_POLARITY_SELECT,
                    DIRECT_CHANNEL_PAD_CONN, DIRECT_CHANNEL_PAD,
                    SI, CS_B, SCLK};

  // two flops per pin; only the second stage is ever read
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  // split the synchronised vector back into named signals
  assign sclk_s = sync2_r[0];
  assign cs_s = sync2_r[1];
  assign si_s = sync2_r[2];
  assign pad_s = sync2_r[3 +: ND];
  assign pad_conn_s = sync2_r[3 + ND +: ND];
  assign pol_s = sync2_r[3 + 2 * ND];
  assign pol_conn_s = sync2_r[4 + 2 * ND];
  assign ilim_s = sync2_r[5 + 2 * ND +: NUM_CH];
  assign ot_s = sync2_r[5 + 2 * ND + NUM_CH +: NUM_CH];
  assign below_ol_s = sync2_r[5 + 2 * ND + 2 * NUM_CH +: NUM_CH];
  assign below_gnd_s = sync2_r[5 + 2 * ND + 3 * NUM_CH +: NUM_CH];

  // delayed copies for edge detection; select idles high
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  // a select fall is only honoured with the serial clock low
  assign cs_fall = ~cs_s & cs_d_r & ~sclk_s;
  assign cs_rise = cs_s & ~cs_d_r;

  // per-channel classification, error latch and status code
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      wire new_err;

      chan_fault_filter #(
        .CNT_W(CNT_W),
        .FILT_CYCLES(FILT_CYCLES)
      ) u_filt (
        .clk(CLK),
        .rst_b(RST_B),
        .chan_on(data_r[g] & direct_ok[g]),
        .ilim(ilim_s[g]),
        .overtemp(ot_s[g]),
        .below_unloaded(below_ol_s[g]),
        .below_gnd(below_gnd_s[g]),
        .live_code(live_code[2*g +: 2])
      );

      assign new_err = (live_code[2*g +: 2] != `STAT_NORMAL);

      // an error in the clearing cycle is kept, set beats clear
      always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          err_vld_r[g] <= 1'b0;
          err_code_r[2*g +: 2] <= `STAT_NORMAL;
        end else if (new_err) begin
          err_vld_r[g] <= 1'b1;
          err_code_r[2*g +: 2] <= live_code[2*g +: 2];
        end else if (cs_rise) begin
          err_vld_r[g] <= 1'b0;
          err_code_r[2*g +: 2] <= `STAT_NORMAL;
        end
      end

      // latched error wins; otherwise the live code is sent
      assign report_code[2*g +: 2] = err_vld_r[g] ?
                                     err_code_r[2*g +: 2] :
                                     live_code[2*g +: 2];

      // highest channel first, so channel 8 leads the frame
      assign status_word[FB-1-2*(NUM_CH-1-g) -: 2] =
        report_code[2*g +: 2];

      // direct pads gate only the first four channels
      if (g < ND) begin : g_direct
        assign direct_ok[g] = pad_active[g];
      end else begin : g_serial
        assign direct_ok[g] = 1'b1;
      end
    end
  endgenerate

  // unconnected polarity select reads as high
  assign pol_high = pol_conn_s ? pol_s : 1'b1;
  // unconnected pads are inactive under either polarity
  assign pad_active = pad_conn_s & ~(pad_s ^ {ND{pol_high}});

  // received frame fields
  assign rx_ctrl = sh_in_r[`CTRL_MSB:`CTRL_LSB];
  assign rx_data = sh_in_r[`DATA_MSB:`DATA_LSB];
  assign frame_full = (bit_cnt_r == `FRAME_CNT_FULL);

  // frame sequencer and shift registers
  always @* begin
    state_nxt = state_r;
    sh_out_nxt = sh_out_r;
    sh_in_nxt = sh_in_r;
    bit_cnt_nxt = bit_cnt_r;
    so_nxt = SO_OUT;
    data_nxt = data_r;
    case (state_r)
      ST_IDLE: begin
        if (cs_fall) begin
          // snapshot every channel's status at the select fall
          sh_out_nxt = status_word;
          so_nxt = status_word[FB-1];
          sh_in_nxt = {FB{1'b0}};
          bit_cnt_nxt = 5'h00;
          state_nxt = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (cs_rise) begin
          // short or long frames are dropped rather than guessed at
          if (frame_full && rx_ctrl == `CTRL_AND_UPDATE)
            data_nxt = rx_data;
          // diagnosis-only and other words change nothing
          state_nxt = ST_IDLE;
        end else begin
          if (sclk_rise) begin
            // the msb was put out at select fall and is held here
            so_nxt = sh_out_r[FB-1];
            sh_out_nxt = {sh_out_r[FB-2:0], 1'b0};
          end
          if (sclk_fall) begin
            sh_in_nxt = {sh_in_r[FB-2:0], si_s};
            if (bit_cnt_r != 5'h1f)
              bit_cnt_nxt = bit_cnt_r + 5'h01;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // frame registers; stored data starts all off
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_IDLE;
      sh_out_r <= {FB{1'b0}};
      sh_in_r <= {FB{1'b0}};
      bit_cnt_r <= 5'h00;
      SO_OUT <= 1'b0;
      data_r <= {NUM_CH{1'b0}};
    end else begin
      state_r <= state_nxt;
      sh_out_r <= sh_out_nxt;
      sh_in_r <= sh_in_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      SO_OUT <= so_nxt;
      data_r <= data_nxt;
    end
  end

  // serial output is released whenever select is high
  assign SO_OE = ~cs_s;

  // overtemperature blocks only its own channel and restarts on cooling
  assign gate_nxt = data_r & direct_ok & ~ot_s;

  // reset holds every gate off regardless of data or pads
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      GATE_ON <= {NUM_CH{1'b0}};
    else
      GATE_ON <= gate_nxt;
  end

  // one-cycle release marker after each select rise; the latches
  // keep set-beats-clear, so no error is lost in the clearing cycle
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      fault_rel_r <= 1'b0;
    else
      fault_rel_r <= cs_rise;
  end

  // open drain: pulled low while any error is latched; let go for
  // the cycle after a select rise so that an error which is still
  // there gives the host a fresh falling edge
  // the pin value itself is always low, only the enable moves
  assign FAULT_B_OUT = 1'b0;
  assign FAULT_B_OE = |err_vld_r & ~fault_rel_r;

endmodule // octal_switch_spi_diag_control

// >>> design/octal_switch_regs.vh
// Purpose: shared constants of the octal switch control block
// Assumes: 50 MHz core clock
// Notes: status codes are two bits per channel, high bit sent first
`ifndef OCTAL_SWITCH_REGS_VH
`define OCTAL_SWITCH_REGS_VH

// two-bit channel status codes
`define STAT_NORMAL 2'h3
`define STAT_OVERLOAD 2'h2
`define STAT_UNLOADED 2'h1
`define STAT_GND_SHORT 2'h0

// control words of the first frame byte
`define CTRL_DIAG_ONLY 8'h00
`define CTRL_AND_UPDATE 8'hff

// frame layout
`define FRAME_BITS 16
`define FRAME_CNT_FULL 5'h10
`define CTRL_MSB 15
`define CTRL_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
`define NUM_CH 8
`define NUM_DIRECT 4

// fault filter delay and its cycle count at the core clock
`define CLK_PERIOD_NS 20
`define FILT_DELAY_NS 100000
// 5000 core cycles of 20 ns, sized for the 16-bit filter counter
`define FILT_CYCLES 16'd5000

`endif

// >>> design/chan_fault_filter.v
// Purpose: one channel's live fault classifier with delay filter
// Assumes: flag inputs are already synchronised to clk
// Notes: a change of off-state fault kind restarts the filter
`timescale 1ns/1ns
`include "octal_switch_regs.vh"

module chan_fault_filter #(
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] FILT_CYCLES = 16'd5000
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // channel state and analog flags
  input wire chan_on,
  input wire ilim,
  input wire overtemp,
  input wire below_unloaded,
  input wire below_gnd,
  // classified status
  output reg [1:0] live_code
);

  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg gnd_kind_r;
  wire off_fault;

  // short to ground pulls lower, so it wins over unloaded
  assign off_fault = ~chan_on & (below_unloaded | below_gnd);

  // filter counter: restarts on on-state, no fault, or kind change
  always @* begin
    cnt_nxt = cnt_r;
    if (!off_fault || (below_gnd != gnd_kind_r)) begin
      cnt_nxt = {CNT_W{1'b0}};
    end else if (cnt_r != FILT_CYCLES) begin
      cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= {CNT_W{1'b0}};
      gnd_kind_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      gnd_kind_r <= below_gnd;
    end
  end

  // status code per channel state
  always @* begin
    live_code = `STAT_NORMAL;
    if (chan_on) begin
      if (ilim || overtemp)
        live_code = `STAT_OVERLOAD;
    end else if (off_fault && cnt_r == FILT_CYCLES) begin
      if (gnd_kind_r)
        live_code = `STAT_GND_SHORT;
      else
        live_code = `STAT_UNLOADED;
    end
  end

endmodule // chan_fault_filter

// >>> tb/octal_switch_spi_diag_control_asserts.sv
// Purpose: pin-level checker of the octal switch control block
// Assumes: bound to the top module, serial pins lag ~3 CLK
// Notes: windows are kept loose where synchronisers add delay
`timescale 1ns/1ns
module octal_switch_spi_diag_control_asserts #(
  parameter NUM_CH = 8
) (
  // clock and reset
  input wire CLK,
  input wire RST_B,
  // serial link
  input wire SCLK,
  input wire CS_B,
  input wire SO_OE,
  // fault pin
  input wire FAULT_B_OUT,
  input wire FAULT_B_OE,
  // direct control
  input wire [3:0] DIRECT_CHANNEL_PAD,
  input wire [3:0] DIRECT_CHANNEL_PAD_CONN,
  input wire INPUT_POLARITY_SELECT,
  input wire INPUT_POLARITY_SELECT_CONN,
  // channels
  input wire [NUM_CH-1:0] OVERTEMP_FLAG,
  input wire [NUM_CH-1:0] GATE_ON
);
  // a floating select reads high; floating pads never count
  wire pol_hi = INPUT_POLARITY_SELECT | ~INPUT_POLARITY_SELECT_CONN;
  wire [3:0] pad_act = DIRECT_CHANNEL_PAD_CONN &
    (pol_hi ? DIRECT_CHANNEL_PAD : ~DIRECT_CHANNEL_PAD);
  reg [NUM_CH-1:0] ot1_r, ot2_r, ot3_r, ot4_r;
  wire [NUM_CH-1:0] ot_all = OVERTEMP_FLAG & ot1_r & ot2_r & ot3_r & ot4_r;
  // heat flag history, so the sync lag is not judged as a fault
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {ot4_r, ot3_r, ot2_r, ot1_r} <= '0;
    end else begin
      {ot4_r, ot3_r, ot2_r, ot1_r} <= {ot3_r, ot2_r, ot1_r, OVERTEMP_FLAG};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_so_release; CS_B [*6] |-> !SO_OE; endproperty
  a_so_release: assert property (p_so_release)
    else $error("serial output driven while deselected");
  property p_so_drive; $fell(CS_B) && !SCLK |-> ##[2:5] SO_OE; endproperty
  a_so_drive: assert property (p_so_drive)
    else $error("serial output not driven after select");
  property p_reset_off; $rose(RST_B) |-> (GATE_ON == '0) [*8]; endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("gate on right after reset");
  property p_float_off;
    (DIRECT_CHANNEL_PAD_CONN == 4'h0) [*5] |-> GATE_ON[3:0] == 4'h0;
  endproperty
  a_float_off: assert property (p_float_off)
    else $error("gate on with floating pads");
  property p_and_pads;
    $stable(pad_act) [*5] |-> (GATE_ON[3:0] & ~pad_act) == 4'h0;
  endproperty
  a_and_pads: assert property (p_and_pads)
    else $error("gate on without active pad");
  property p_thermal; (GATE_ON & ot_all) == '0; endproperty
  a_thermal: assert property (p_thermal)
    else $error("gate on while overheated");
  property p_fault_pin; FAULT_B_OE |-> !FAULT_B_OUT; endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin enabled but not low");
  property p_clear_cs; $fell(FAULT_B_OE) |-> CS_B; endproperty
  a_clear_cs: assert property (p_clear_cs)
    else $error("fault released while selected");
  property p_hold_gates;
    (!CS_B && $stable(pad_act) && $stable(OVERTEMP_FLAG)) [*6]
      |-> $stable(GATE_ON);
  endproperty
  a_hold_gates: assert property (p_hold_gates)
    else $error("gates moved inside a frame");
  property p_fault_release;
    $rose(CS_B) && FAULT_B_OE |-> ##[1:4] !FAULT_B_OE;
  endproperty
  a_fault_release: assert property (p_fault_release)
    else $error("fault pin not released at select rise");
endmodule // octal_switch_spi_diag_control_asserts

bind octal_switch_spi_diag_control octal_switch_spi_diag_control_asserts
  #(.NUM_CH(NUM_CH)) chk (.CLK(CLK), .RST_B(RST_B), .SCLK(SCLK),
  .CS_B(CS_B), .SO_OE(SO_OE), .FAULT_B_OUT(FAULT_B_OUT),
  .FAULT_B_OE(FAULT_B_OE), .DIRECT_CHANNEL_PAD(DIRECT_CHANNEL_PAD),
  .DIRECT_CHANNEL_PAD_CONN(DIRECT_CHANNEL_PAD_CONN),
  .INPUT_POLARITY_SELECT(INPUT_POLARITY_SELECT),
  .INPUT_POLARITY_SELECT_CONN(INPUT_POLARITY_SELECT_CONN),
  .OVERTEMP_FLAG(OVERTEMP_FLAG), .GATE_ON(GATE_ON));

// >>> tb/spi_host_model.sv
// Purpose: host that frames control and data onto the serial link
// Assumes: link clock idles low, half period counted in CLK
// Notes: serial output read at the end of each low half
`timescale 1ns/1ns
module spi_host_model (
  // pacing clock
  input wire clk,
  // serial link
  input wire so,
  output logic sclk,
  output logic cs_b,
  output logic si
);
  int half = 4; // 4 CLK gives the 160 ns link clock
  // idle link
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
  end
  // shift nbits of tx msb first; fewer than 16 makes a bad frame
  task automatic frame(input logic [15:0] tx, input int nbits,
                       output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk);
    cs_b <= 1'b0; // drops while sclk low, held all frame
    repeat (half) @(posedge clk);
    for (int i = 15; i > 15 - nbits; i--) begin
      si <= tx[i];
      sclk <= 1'b1;
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
      repeat (half) @(posedge clk);
      rx[i] = so;
    end
    cs_b <= 1'b1;
    si <= ~si; // a released line must not keep its last value
    repeat (8) @(posedge clk);
  endtask
endmodule // spi_host_model

// >>> tb/tb_octal_switch_spi_diag_control.sv
// Purpose: self-checking bench of the octal switch control block
// Assumes: host model drives the link, filter cut to 20 cycles
// Notes: faults other than the brief ground short are held twice the filter so they are surely seen
`timescale 1ns/1ns
module tb_octal_switch_spi_diag_control;
  localparam int FILT = 20;
  typedef struct packed {
    logic [15:0] tx;
    logic [3:0] pad;
    logic [3:0] conn;
    logic pol;
    logic pc;
    logic [7:0] gate;
  } row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sclk, cs_b, si, so_out, so_oe, fault_out, fault_oe;
  logic [3:0] pad = 4'hf, pad_conn = 4'hf;
  logic pol = 1'b1, pol_conn = 1'b1;
  logic [7:0] ilim = 8'h00, hot = 8'h00, unl = 8'h00, gsh = 8'h00;
  logic [7:0] gate;
  logic [15:0] rx;
  int err_count = 0, check_count = 0, cycles = 0;
  row_t rows [9] = '{
    '{16'hffa5, 4'hf, 4'hf, 1'b1, 1'b1, 8'ha5},
    '{16'hff0f, 4'h0, 4'hf, 1'b0, 1'b1, 8'h0f},
    '{16'hff0f, 4'hf, 4'hf, 1'b0, 1'b1, 8'h00},
    '{16'h00ff, 4'hf, 4'hf, 1'b1, 1'b1, 8'h0f},
    '{16'hffff, 4'hf, 4'h0, 1'b1, 1'b1, 8'hf0},
    '{16'h3c0f, 4'hf, 4'hf, 1'b1, 1'b1, 8'hff},
    '{16'hff0f, 4'h5, 4'hf, 1'b0, 1'b0, 8'h05},
    '{16'h0000, 4'hf, 4'hf, 1'b1, 1'b1, 8'h0f},
    '{16'hff81, 4'hf, 4'hf, 1'b1, 1'b1, 8'h81}};
  // released serial output shows the inverse; fault line has a pull-up
  wire so_line = so_oe ? so_out : ~so_out;
  wire fault_line = fault_oe ? fault_out : 1'b1;

  octal_switch_spi_diag_control #(.FILT_CYCLES(16'(FILT))) dut (
    .CLK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b), .SI(si),
    .SO_OUT(so_out), .SO_OE(so_oe), .FAULT_B_OUT(fault_out),
    .FAULT_B_OE(fault_oe), .DIRECT_CHANNEL_PAD(pad),
    .DIRECT_CHANNEL_PAD_CONN(pad_conn), .INPUT_POLARITY_SELECT(pol),
    .INPUT_POLARITY_SELECT_CONN(pol_conn), .CURRENT_LIMIT_FLAG(ilim),
    .OVERTEMP_FLAG(hot), .BELOW_UNLOADED_THRESHOLD(unl),
    .BELOW_GND_SHORT_THRESHOLD(gsh), .GATE_ON(gate));
  spi_host_model host (.clk(clk), .so(so_line), .sclk(sclk),
    .cs_b(cs_b), .si(si));

  always #10 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // the whole run needs about 2700 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected at %0t: run hung", $time);
      results();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      pad <= rows[i].pad;
      pad_conn <= rows[i].conn;
      pol <= rows[i].pol;
      pol_conn <= rows[i].pc;
      repeat (6) @(posedge clk);
      host.frame(rows[i].tx, 16, rx);
      chk(rx, 16'hffff);
      chk(16'(gate[3:0]), 16'(rows[i].gate[3:0]));
      chk(16'(gate[7:4]), 16'(rows[i].gate[7:4]));
      $display("row %0d done", i);
    end
    // bad frame length, then a slow host
    host.frame(16'hff00, 12, rx);
    chk({8'h00, gate}, 16'h0081);
    host.half = 7;
    host.frame(16'hff3c, 16, rx);
    chk(rx, 16'hffff);
    chk({8'h00, gate}, 16'h003c);
    host.half = 4;
    host.frame(16'hff81, 16, rx);
    $display("framing done");
    // faults: brief ground short, open load, overload, heat
    unl <= 8'h05;
    ilim <= 8'h90;
    hot <= 8'h80;
    gsh <= 8'h02;
    repeat (FILT / 2) @(posedge clk);
    gsh <= 8'h00;
    repeat (2 * FILT) @(posedge clk);
    chk({8'h00, gate}, 16'h0001);
    chk({15'h0, fault_line}, 16'h0000);
    host.frame(16'h0000, 16, rx);
    chk(rx, 16'hbfdf);
    unl <= 8'h00;
    ilim <= 8'h00;
    hot <= 8'h00;
    gsh <= 8'h02;
    repeat (2 * FILT) @(posedge clk);
    chk({8'h00, gate}, 16'h0081);
    host.frame(16'h0000, 16, rx);
    chk(rx, 16'hbfd3);
    gsh <= 8'h00;
    repeat (2 * FILT) @(posedge clk);
    chk({15'h0, fault_line}, 16'h0000);
    host.frame(16'h0000, 16, rx);
    chk(rx, 16'hfff3);
    host.frame(16'h0000, 16, rx);
    chk(rx, 16'hffff);
    chk({15'h0, fault_line}, 16'h0001);
    $display("faults done");
    // reset in mid-run
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk({8'h00, gate}, 16'h0000);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    host.frame(16'h0000, 16, rx);
    chk({8'h00, gate}, 16'h0000);
    $display("reset done");
    results();
  end
endmodule // tb_octal_switch_spi_diag_control
